// ===== itq_defines.vh
// constants for the interrupt translation command queue front end
`ifndef ITQ_DEFINES_VH
`define ITQ_DEFINES_VH
// register offsets (byte addresses, 64-bit registers read as two words)
`define ITQ_OFF_CTRL        12'h000
`define ITQ_OFF_XLATE       12'h040
`define ITQ_OFF_CBASE_LO    12'h080
`define ITQ_OFF_CBASE_HI    12'h084
`define ITQ_OFF_CWRITE      12'h088
`define ITQ_OFF_CREAD       12'h090
`define ITQ_OFF_VPE_SEL     12'h0a0
`define ITQ_OFF_VPE_LO      12'h0a4
`define ITQ_OFF_VPE_MID     12'h0a8
`define ITQ_OFF_VPE_HI      12'h0ac
// control fields
`define ITQ_CTRL_EN_BIT     0
// queue base fields (64-bit view)
`define ITQ_CB_VALID_BIT    63
`define ITQ_CB_CACHE_MSB    61
`define ITQ_CB_CACHE_LSB    59
`define ITQ_CB_SHARE_MSB    11
`define ITQ_CB_SHARE_LSB    10
`define ITQ_CB_SIZE_MSB     7
`define ITQ_CB_SIZE_LSB     0
`define ITQ_CB_ADDR_MSB     51
`define ITQ_CB_ADDR_LSB     16
// pointer fields: offsets in 32-byte entries
`define ITQ_PTR_MSB         19
`define ITQ_PTR_LSB         5
`define ITQ_STALL_BIT       0
`define ITQ_ENTRY_BYTES     32
`define ITQ_ENTRIES_PER_PG  15'h0080
`define ITQ_PAGE_SHIFT      7
// command layout and opcodes
`define ITQ_CMD_BEATS       4
`define ITQ_OP_INJECT       8'h03
`define ITQ_OP_SYNC         8'h05
`define ITQ_OP_VSYNC        8'h25
// virtual-PE table layout
`define ITQ_VPE_IDX_W       16
`define ITQ_VPE_DEPTH       16
`define ITQ_VPE_SEL_W       4
`define ITQ_RD_W            32
`define ITQ_VPT_W           52
`define ITQ_VRANGE_W        5
// fifo
`define ITQ_FIFO_DEPTH      16
`define ITQ_FIFO_AW         4
`endif

// ===== itq_top.v
// command queue fetch/execute engine, control registers, vpe table and fifo
`include "itq_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// fifo between memory read data and the command decoder
module itq_fifo #(
	parameter WIDTH = 64,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             clock_in,
	input  wire             rst_n_in,
	input  wire             flush_in,
	// fill side
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	// drain side
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW:0]      wr_ff;
	reg [AW:0]      rd_ff;
	wire            full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
	wire            empty = (wr_ff == rd_ff);
	wire            push  = in_valid_in && !full;
	wire            pop   = out_ready_in && !empty;
	assign in_ready_out  = !full;
	assign out_valid_out = !empty;
	assign out_data_out  = mem_ff[rd_ff[AW-1:0]];
	// storage has no reset; only pointers need a defined value
	always @(posedge clock_in) begin
		if (push)
			mem_ff[wr_ff[AW-1:0]] <= in_data_in;
	end
	// pointers, flush drops stale prefetch
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ff <= {(AW+1){1'b0}};
			rd_ff <= {(AW+1){1'b0}};
		end else if (flush_in) begin
			wr_ff <= {(AW+1){1'b0}};
			rd_ff <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ff <= wr_ff + {{AW{1'b0}}, 1'b1};
			if (pop)
				rd_ff <= rd_ff + {{AW{1'b0}}, 1'b1};
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Contract
// - vpe index selects table entry: target, base
// - entry holds valid, target, pending base, range
// - entry pending base drives redistributor schedule
// - one global enable bit in control
// - request port takes event number, requester pin
// - queue base: valid, attributes, address, pages
// - 32-byte entries, pointers step by 32
// - command words read little-endian
// - base 64KB aligned, low bits ignored
// - wrap at base plus pages times 4KB
// - all memory reads are non-secure
// - commands run in order, pointer then advances
// - read pointer wraps to offset zero
// - equal pointers mean empty queue
// - stall flag halts command processing
// - requests see state before or after command
// - after barrier, requests see earlier commands
// - inject command raises an interrupt
// - barrier waits redistributor observed before continuing
// - inject translates pair, sets pending at target
module itq_top (
	// clock and reset
	input  wire        clock_in,
	input  wire        rst_n_in,
	// register port
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	input  wire [11:0] reg_addr_in,
	input  wire [31:0] reg_wdata_in,
	output reg  [31:0] reg_rdata_ff_out,
	// requester number accompanying a request port write
	input  wire [31:0] requester_number_in,
	// memory read request, little-endian 64-bit beats
	output reg         mem_req_ff_out,
	output reg  [51:0] mem_addr_ff_out,
	output reg         mem_nonsecure_ff_out,
	output reg  [2:0]  mem_cache_ff_out,
	output reg  [1:0]  mem_share_ff_out,
	input  wire        mem_gnt_in,
	input  wire        mem_rvalid_in,
	input  wire [63:0] mem_rdata_in,
	output wire        mem_rready_out,
	// translation request toward the redistributors
	output reg         xlate_valid_ff_out,
	output reg  [31:0] xlate_requester_ff_out,
	output reg  [31:0] xlate_event_ff_out,
	output reg         xlate_inject_ff_out,
	// barrier handshake toward the redistributors
	output reg         barrier_req_ff_out,
	output reg  [31:0] barrier_target_ff_out,
	input  wire        barrier_done_in,
	// virtual pe schedule lookup
	input  wire [15:0] virtual_pe_index_in,
	output reg         vpe_valid_ff_out,
	output reg  [31:0] redistributor_target_ff_out,
	output reg  [51:0] virtual_pending_base_reg_ff_out,
	output reg  [4:0]  vpe_range_ff_out
);
	localparam ST_IDLE = 3'd0, ST_REQ = 3'd1, ST_COLL = 3'd2, ST_EXEC = 3'd3, ST_SYNC = 3'd4;
	reg        translation_global_enable_ff;
	reg [63:0] command_queue_base_ff;
	reg [14:0] wr_ptr_ff;
	reg [14:0] rd_ptr_ff;
	reg        stall_ff;
	reg [2:0]  state_ff;
	reg [1:0]  beat_ff;
	reg [63:0] cmd_w0_ff;
	reg [63:0] cmd_w2_ff;
	reg [3:0]  vpe_sel_ff;
	// vpe table storage
	reg                     vt_valid [0:`ITQ_VPE_DEPTH-1];
	reg [`ITQ_RD_W-1:0]     vt_rd    [0:`ITQ_VPE_DEPTH-1];
	reg [`ITQ_VPT_W-1:0]    vt_vpt   [0:`ITQ_VPE_DEPTH-1];
	reg [`ITQ_VRANGE_W-1:0] vt_rng   [0:`ITQ_VPE_DEPTH-1];
	wire        f_valid;
	wire [63:0] f_data;
	wire        f_pop = (state_ff == ST_COLL) && f_valid;
	wire        q_valid = command_queue_base_ff[`ITQ_CB_VALID_BIT];
	wire [7:0]  pages = command_queue_base_ff[`ITQ_CB_SIZE_MSB:`ITQ_CB_SIZE_LSB];
	// number of entries in queue; page count field holds pages minus one
	wire [15:0] q_entries = {1'b0, pages, 7'h00} + {1'b0, `ITQ_ENTRIES_PER_PG};
	wire [15:0] rd_next = {1'b0, rd_ptr_ff} + 16'h0001;
	wire [14:0] rd_wrap = (rd_next >= q_entries) ? 15'h0000 : rd_next[14:0];
	wire        q_empty = (rd_ptr_ff == wr_ptr_ff);
	wire        run = translation_global_enable_ff && q_valid && !stall_ff;
	wire [51:0] base_addr = {command_queue_base_ff[`ITQ_CB_ADDR_MSB:`ITQ_CB_ADDR_LSB],
		16'h0000};
	wire [7:0]  opcode = cmd_w0_ff[7:0];
	wire        wr_hit = reg_wr_in;
	wire [3:0]  lu_idx = virtual_pe_index_in[`ITQ_VPE_SEL_W-1:0];
	wire        lu_in_range = (virtual_pe_index_in[15:`ITQ_VPE_SEL_W] == 12'h000);
	wire        opc_ok = (opcode == `ITQ_OP_INJECT) || (opcode == `ITQ_OP_SYNC) ||
		(opcode == `ITQ_OP_VSYNC) || (opcode == 8'h00);
	assign mem_rready_out = 1'b1;
	// command beat buffer; read data always accepted, fifo absorbs bursts
	itq_fifo #(.WIDTH(64), .DEPTH(`ITQ_FIFO_DEPTH), .AW(`ITQ_FIFO_AW)) u_fifo (
		.clock_in      (clock_in),
		.rst_n_in      (rst_n_in),
		.flush_in      (!run && state_ff == ST_IDLE),
		.in_valid_in   (mem_rvalid_in),
		.in_ready_out  (),
		.in_data_in    (mem_rdata_in),
		.out_valid_out (f_valid),
		.out_ready_in  (f_pop),
		.out_data_out  (f_data)
	);
	// control registers and command engine
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			translation_global_enable_ff <= 1'b0;
			command_queue_base_ff        <= 64'h0000000000000000;
			wr_ptr_ff                    <= 15'h0000;
			rd_ptr_ff                    <= 15'h0000;
			stall_ff                     <= 1'b0;
			state_ff                     <= ST_IDLE;
			beat_ff                      <= 2'd0;
			cmd_w0_ff                    <= 64'h0000000000000000;
			cmd_w2_ff                    <= 64'h0000000000000000;
			vpe_sel_ff                   <= 4'h0;
			mem_req_ff_out               <= 1'b0;
			mem_addr_ff_out              <= 52'h0000000000000;
			mem_nonsecure_ff_out         <= 1'b1;
			mem_cache_ff_out             <= 3'h0;
			mem_share_ff_out             <= 2'h0;
			xlate_valid_ff_out           <= 1'b0;
			xlate_requester_ff_out       <= 32'h00000000;
			xlate_event_ff_out           <= 32'h00000000;
			xlate_inject_ff_out          <= 1'b0;
			barrier_req_ff_out           <= 1'b0;
			barrier_target_ff_out        <= 32'h00000000;
		end else begin
			xlate_valid_ff_out <= 1'b0;
			// register writes; write pointer is software owned
			if (wr_hit) begin
				case (reg_addr_in)
					`ITQ_OFF_CTRL:
						translation_global_enable_ff <= reg_wdata_in[`ITQ_CTRL_EN_BIT];
					`ITQ_OFF_CBASE_LO: command_queue_base_ff[31:0] <= reg_wdata_in;
					`ITQ_OFF_CBASE_HI: command_queue_base_ff[63:32] <= reg_wdata_in;
					`ITQ_OFF_CWRITE:
						wr_ptr_ff <= reg_wdata_in[`ITQ_PTR_MSB:`ITQ_PTR_LSB];
					`ITQ_OFF_CREAD:
						if (!translation_global_enable_ff) begin
							rd_ptr_ff <= reg_wdata_in[`ITQ_PTR_MSB:`ITQ_PTR_LSB];
							stall_ff  <= 1'b0;
						end
					`ITQ_OFF_VPE_SEL: vpe_sel_ff <= reg_wdata_in[3:0];
					`ITQ_OFF_XLATE: begin
						// translation request from a requester, only when enabled
						xlate_valid_ff_out     <= translation_global_enable_ff;
						xlate_requester_ff_out <= requester_number_in;
						xlate_event_ff_out     <= reg_wdata_in;
						xlate_inject_ff_out    <= 1'b0;
					end
					default: ;
				endcase
			end
			// requests issue in any state; an inject command waits out any register write cycle, so each command is atomic
			case (state_ff)
				ST_IDLE: // beat count is back at zero: four beats wrap the 2-bit counter
					if (run && !q_empty && !xlate_valid_ff_out) begin
						mem_req_ff_out       <= 1'b1;
						mem_addr_ff_out      <= base_addr + {32'h00000000, rd_ptr_ff, 5'h00};
						mem_nonsecure_ff_out <= 1'b1;
						mem_cache_ff_out     <= command_queue_base_ff[`ITQ_CB_CACHE_MSB:`ITQ_CB_CACHE_LSB];
						mem_share_ff_out     <= command_queue_base_ff[`ITQ_CB_SHARE_MSB:`ITQ_CB_SHARE_LSB];
						state_ff             <= ST_REQ;
					end
				ST_REQ:
					if (mem_gnt_in) begin
						mem_req_ff_out <= 1'b0;
						state_ff       <= ST_COLL;
					end
				ST_COLL:
					if (f_valid) begin
						// little-endian beats: beat 0 holds bytes 0..7
						if (beat_ff == 2'd0)
							cmd_w0_ff <= f_data;
						if (beat_ff == 2'd2)
							cmd_w2_ff <= f_data;
						beat_ff <= beat_ff + 2'd1;
						if (beat_ff == 2'd3)
							state_ff <= ST_EXEC;
					end
				ST_EXEC:
					if (!opc_ok) begin
						// unknown command stalls the queue without advancing
						stall_ff <= 1'b1;
						state_ff <= ST_IDLE;
					end else if (opcode == `ITQ_OP_INJECT && !wr_hit) begin
						xlate_valid_ff_out     <= 1'b1;
						xlate_requester_ff_out <= cmd_w0_ff[63:32];
						xlate_event_ff_out     <= cmd_w2_ff[31:0];
						xlate_inject_ff_out    <= 1'b1;
						rd_ptr_ff              <= rd_wrap;
						state_ff               <= ST_IDLE;
					end else if (opcode == `ITQ_OP_SYNC || opcode == `ITQ_OP_VSYNC) begin
						barrier_req_ff_out    <= 1'b1;
						barrier_target_ff_out <= cmd_w2_ff[47:16];
						state_ff              <= ST_SYNC;
					end else if (opcode == 8'h00) begin
						rd_ptr_ff <= rd_wrap;
						state_ff  <= ST_IDLE;
					end
				ST_SYNC:
					if (barrier_done_in) begin
						barrier_req_ff_out <= 1'b0;
						rd_ptr_ff          <= rd_wrap;
						state_ff           <= ST_IDLE;
					end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end
	// vpe table entries written through the window registers
	genvar gi;
	generate
		for (gi = 0; gi < `ITQ_VPE_DEPTH; gi = gi + 1) begin : g_vt
			always @(posedge clock_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					vt_valid[gi] <= 1'b0;
					vt_rd[gi]    <= 32'h00000000;
					vt_vpt[gi]   <= 52'h0000000000000;
					vt_rng[gi]   <= 5'h00;
				end else if (wr_hit && vpe_sel_ff == gi) begin
					if (reg_addr_in == `ITQ_OFF_VPE_LO)
						vt_rd[gi] <= reg_wdata_in;
					if (reg_addr_in == `ITQ_OFF_VPE_MID)
						vt_vpt[gi][31:0] <= reg_wdata_in;
					if (reg_addr_in == `ITQ_OFF_VPE_HI) begin
						vt_vpt[gi][51:32] <= reg_wdata_in[19:0];
						vt_rng[gi]        <= reg_wdata_in[28:24];
						vt_valid[gi]      <= reg_wdata_in[31];
					end
				end
			end
		end
	endgenerate
	// lookup by 16-bit index; out-of-range index reads invalid
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			vpe_valid_ff_out                <= 1'b0;
			redistributor_target_ff_out     <= 32'h00000000;
			virtual_pending_base_reg_ff_out <= 52'h0000000000000;
			vpe_range_ff_out                <= 5'h00;
		end else begin
			vpe_valid_ff_out                <= lu_in_range && vt_valid[lu_idx];
			redistributor_target_ff_out     <= vt_rd[lu_idx];
			virtual_pending_base_reg_ff_out <= vt_vpt[lu_idx];
			vpe_range_ff_out                <= vt_rng[lu_idx];
		end
	end
	// register read data, unmapped offsets read zero
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in)
			reg_rdata_ff_out <= 32'h00000000;
		else if (reg_rd_in) begin
			case (reg_addr_in)
				`ITQ_OFF_CTRL:     reg_rdata_ff_out <= {31'h0, translation_global_enable_ff};
				`ITQ_OFF_CBASE_LO: reg_rdata_ff_out <= command_queue_base_ff[31:0];
				`ITQ_OFF_CBASE_HI: reg_rdata_ff_out <= command_queue_base_ff[63:32];
				`ITQ_OFF_CWRITE:   reg_rdata_ff_out <= {12'h000, wr_ptr_ff, 5'h00};
				`ITQ_OFF_CREAD:    reg_rdata_ff_out <= {12'h000, rd_ptr_ff, 4'h0, stall_ff};
				`ITQ_OFF_VPE_SEL:  reg_rdata_ff_out <= {28'h0000000, vpe_sel_ff};
				`ITQ_OFF_VPE_LO:   reg_rdata_ff_out <= vt_rd[vpe_sel_ff];
				`ITQ_OFF_VPE_MID:  reg_rdata_ff_out <= vt_vpt[vpe_sel_ff][31:0];
				`ITQ_OFF_VPE_HI:   reg_rdata_ff_out <= {vt_valid[vpe_sel_ff], 2'b00,
					vt_rng[vpe_sel_ff], 4'h0, vt_vpt[vpe_sel_ff][51:32]};
				default:           reg_rdata_ff_out <= 32'h00000000;
			endcase
		end
	end
endmodule

// ===== itq_mem_model.sv
// memory and redistributor stand-in for the command queue front end
module itq_mem_model (
	// clock and latency knob
	input  wire logic        clock_in,
	input  wire logic [1:0]  lat_in,
	// command fetch side
	input  wire logic        mem_req_in,
	input  wire logic [51:0] mem_addr_in,
	output logic             mem_gnt_out,
	output logic             mem_rvalid_out,
	output logic [63:0]      mem_rdata_out,
	// barrier side
	input  wire logic        barrier_req_in,
	output logic             barrier_done_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [255:0] cmd [logic [51:0]];
	logic [51:0]  a;
	initial {mem_gnt_out, mem_rvalid_out, mem_rdata_out, barrier_done_out} = '0;
	// grant after a delay, then four beats; idle data toggles so stale data never looks valid
	always begin
		@(posedge clock_in);
		mem_rdata_out <= ~mem_rdata_out;
		if (mem_req_in) begin
			a = mem_addr_in;
			repeat (lat_in) @(posedge clock_in);
			mem_gnt_out <= 1'b1;
			@(posedge clock_in);
			mem_gnt_out <= 1'b0;
			for (int k = 0; k < 4; k++) begin
				mem_rvalid_out <= 1'b1;
				mem_rdata_out <= cmd[a][64*k +: 64];
				@(posedge clock_in);
			end
			mem_rvalid_out <= 1'b0;
		end
	end
	// barrier acknowledge, one cycle wide, after the same delay
	always begin
		@(posedge clock_in);
		if (barrier_req_in && !barrier_done_out) begin
			repeat (lat_in) @(posedge clock_in);
			barrier_done_out <= 1'b1;
			@(posedge clock_in);
			barrier_done_out <= 1'b0;
			@(posedge clock_in);
		end
	end
endmodule

// ===== itq_top_sva.sv
// port assertions for the command queue front end
`include "itq_defines.vh"
module itq_top_sva (
	// clock and reset
	input wire        clock_in,
	input wire        rst_n_in,
	// register port
	input wire        reg_rd_in,
	input wire [11:0] reg_addr_in,
	input wire [31:0] reg_rdata_ff_out,
	// memory, barrier and vpe lookup
	input wire        mem_req_ff_out,
	input wire [51:0] mem_addr_ff_out,
	input wire        mem_nonsecure_ff_out,
	input wire        mem_gnt_in,
	input wire        xlate_valid_ff_out,
	input wire        barrier_req_ff_out,
	input wire        barrier_done_in,
	input wire [15:0] virtual_pe_index_in,
	input wire        vpe_valid_ff_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	property p_nonsec; mem_nonsecure_ff_out; endproperty
	a_nonsec: assert property (p_nonsec)
		else $error("fetch not non-secure");
	property p_align; mem_req_ff_out |-> mem_addr_ff_out[4:0] == 5'h00; endproperty
	a_align: assert property (p_align)
		else $error("fetch address not on a 32-byte entry");
	property p_hold; mem_req_ff_out && !mem_gnt_in |=> mem_req_ff_out && $stable(mem_addr_ff_out);
	endproperty
	a_hold: assert property (p_hold)
		else $error("fetch request dropped before grant");
	property p_gnt; mem_req_ff_out && mem_gnt_in |=> !mem_req_ff_out; endproperty
	a_gnt: assert property (p_gnt)
		else $error("fetch request stayed after grant");
	property p_bhold; barrier_req_ff_out && !barrier_done_in |=> barrier_req_ff_out; endproperty
	a_bhold: assert property (p_bhold)
		else $error("barrier released before acknowledge");
	property p_bexcl; barrier_req_ff_out |-> !mem_req_ff_out; endproperty
	a_bexcl: assert property (p_bexcl)
		else $error("fetch during barrier");
	property p_pulse; xlate_valid_ff_out |=> !xlate_valid_ff_out; endproperty
	a_pulse: assert property (p_pulse)
		else $error("translation pulse too long");
	property p_oob; virtual_pe_index_in[15:4] != 12'h000 |=> !vpe_valid_ff_out; endproperty
	a_oob: assert property (p_oob)
		else $error("vpe index beyond table gave valid");
	property p_ctrl; reg_rd_in && reg_addr_in == `ITQ_OFF_CTRL |=> reg_rdata_ff_out[31:1] == 0;
	endproperty
	a_ctrl: assert property (p_ctrl)
		else $error("control has more than the enable bit");
	property p_cread; reg_rd_in && reg_addr_in == `ITQ_OFF_CREAD |=> reg_rdata_ff_out[4:1] == 0;
	endproperty
	a_cread: assert property (p_cread)
		else $error("read pointer not in entry steps");
endmodule
bind itq_top itq_top_sva u_sva (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_rd_in(reg_rd_in),
	.reg_addr_in(reg_addr_in), .reg_rdata_ff_out(reg_rdata_ff_out),
	.mem_req_ff_out(mem_req_ff_out), .mem_addr_ff_out(mem_addr_ff_out),
	.mem_nonsecure_ff_out(mem_nonsecure_ff_out), .mem_gnt_in(mem_gnt_in),
	.xlate_valid_ff_out(xlate_valid_ff_out), .barrier_req_ff_out(barrier_req_ff_out),
	.barrier_done_in(barrier_done_in), .virtual_pe_index_in(virtual_pe_index_in),
	.vpe_valid_ff_out(vpe_valid_ff_out));

// ===== interrupt_translation_cmd_queue_tb.sv
// self-checking bench for the command queue front end
`include "itq_defines.vh"
module interrupt_translation_cmd_queue_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_in, rst_n_in, reg_wr_in, reg_rd_in, mem_gnt_in, mem_rvalid_in;
	logic        mem_req_ff_out, mem_nonsecure_ff_out, mem_rready_out, xlate_valid_ff_out;
	logic        xlate_inject_ff_out, barrier_req_ff_out, barrier_done_in, vpe_valid_ff_out;
	logic [11:0] reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_ff_out, requester_number_in, xlate_requester_ff_out;
	logic [31:0] xlate_event_ff_out, barrier_target_ff_out, redistributor_target_ff_out, d, r, v;
	logic [51:0] mem_addr_ff_out, virtual_pending_base_reg_ff_out, aq[$];
	logic [63:0] mem_rdata_in;
	logic [2:0]  mem_cache_ff_out;
	logic [1:0]  mem_share_ff_out, lat;
	logic [15:0] virtual_pe_index_in;
	logic [4:0]  vpe_range_ff_out;
	logic [64:0] xq[$];
	logic [31:0] bq[$];
	logic [31:0] seed = 32'hd76f2f96;
	logic        req_d = 0, bar_d = 0;
	int          err_total, n_compared, cyc;
	localparam logic [51:0] BASE = 52'h00abc_1230_0000;
	logic [7:0]  ops[4] = '{`ITQ_OP_INJECT, `ITQ_OP_SYNC, `ITQ_OP_VSYNC, 8'h00};
	logic [11:0] offs[4] = '{`ITQ_OFF_CTRL, `ITQ_OFF_CWRITE, `ITQ_OFF_CREAD, 12'h0f0};
	itq_top dut_u (.*);
	itq_mem_model u_mem (.clock_in(clock_in), .lat_in(lat), .mem_req_in(mem_req_ff_out),
		.mem_addr_in(mem_addr_ff_out), .mem_gnt_out(mem_gnt_in), .mem_rvalid_out(mem_rvalid_in),
		.mem_rdata_out(mem_rdata_in), .barrier_req_in(barrier_req_ff_out),
		.barrier_done_out(barrier_done_in));
	// clock and hang guard
	initial begin
		clock_in = 0;
		forever #2 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string n, logic [95:0] s, logic [95:0] e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// register accesses: one strobe cycle, then a quiet cycle so strobes never collide
	task automatic wr(logic [11:0] a, logic [31:0] x);
		{reg_wr_in, reg_addr_in, reg_wdata_in} = {1'b1, a, x};
		@(negedge clock_in);
		reg_wr_in = 0;
		@(negedge clock_in);
	endtask
	task automatic rd(logic [11:0] a, output logic [31:0] x);
		{reg_rd_in, reg_addr_in} = {1'b1, a};
		@(negedge clock_in);
		x = reg_rdata_ff_out;
		reg_rd_in = 0;
		@(negedge clock_in);
	endtask
	task automatic poll(logic [31:0] x);
		repeat (100) begin
			rd(`ITQ_OFF_CREAD, d);
			if (d === x) break;
		end
		chk("read_pointer", d, x);
	endtask
	// place a command at an entry and record what the device must do with it
	task automatic put(int e, logic [7:0] op);
		r = rnd();
		v = rnd();
		u_mem.cmd[BASE + e * 32] = {64'h0, op == `ITQ_OP_INJECT ? {32'h0, v} : {16'h0, v, 16'h0},
			64'h0, r, 24'h0, op};
		aq.push_back(BASE + e * 32);
		if (op == `ITQ_OP_INJECT) xq.push_back({1'b1, r, v});
		else if (op != 8'h00 && op != 8'h7f) bq.push_back(v);
	endtask
	// observer: every output event is matched against the reference queues
	always @(negedge clock_in) begin
		if (xlate_valid_ff_out) chk("xlate",
			{xlate_inject_ff_out, xlate_requester_ff_out, xlate_event_ff_out}, xq.pop_front());
		if (mem_req_ff_out && !req_d) chk("fetch",
			{mem_nonsecure_ff_out, mem_rready_out, mem_cache_ff_out, mem_share_ff_out,
			mem_addr_ff_out}, {7'b1110110, aq.pop_front()});
		if (barrier_req_ff_out && !bar_d) chk("barrier",
			barrier_target_ff_out, bq.pop_front());
		req_d <= mem_req_ff_out;
		bar_d <= barrier_req_ff_out;
	end
	initial begin
		{reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, virtual_pe_index_in, lat} = '0;
		requester_number_in = rnd();
		rst_n_in = 0;
		repeat (6) @(negedge clock_in);
		rst_n_in = 1;
		foreach (offs[i]) begin
			rd(offs[i], d);
			chk("reset_read", d, 0);
		end
		wr(`ITQ_OFF_XLATE, rnd());
		wr(`ITQ_OFF_CBASE_LO, 32'h1230_5800);
		wr(`ITQ_OFF_CBASE_HI, 32'ha800_0abc);
		rd(`ITQ_OFF_CBASE_HI, d);
		chk("queue_base", d, 32'ha800_0abc);
		wr(`ITQ_OFF_CREAD, 126 << 5);
		wr(`ITQ_OFF_CWRITE, 3 << 5);
		foreach (ops[i]) put((126 + i) % 128, ops[i]);
		put(2, 8'h7f);
		repeat (10) @(negedge clock_in);
		lat = 2'(rnd());
		wr(`ITQ_OFF_CTRL, 1);
		poll((2 << 5) | 1);
		wr(`ITQ_OFF_CWRITE, 4 << 5);
		repeat (20) @(negedge clock_in);
		rd(`ITQ_OFF_CREAD, d);
		chk("stalled", d, (2 << 5) | 1);
		put(3, `ITQ_OP_INJECT);
		wr(`ITQ_OFF_CTRL, 0);
		wr(`ITQ_OFF_CREAD, 3 << 5);
		wr(`ITQ_OFF_CTRL, 1);
		poll(4 << 5);
		for (int e = 4; e < 10; e++) put(e, ops[rnd() % 4]);
		lat = 2'(rnd());
		wr(`ITQ_OFF_CWRITE, 10 << 5);
		poll(10 << 5);
		requester_number_in = rnd();
		v = rnd();
		xq.push_back({1'b0, requester_number_in, v});
		wr(`ITQ_OFF_XLATE, v);
		wr(`ITQ_OFF_CTRL, 0);
		repeat (4) begin
			v = rnd();
			r = rnd();
			wr(`ITQ_OFF_VPE_SEL, {28'h0, v[3:0]});
			wr(`ITQ_OFF_VPE_LO, r);
			wr(`ITQ_OFF_VPE_MID, seed);
			wr(`ITQ_OFF_VPE_HI, {3'b100, v[8:4], 4'h0, v[31:12]});
			virtual_pe_index_in = {12'h0, v[3:0]};
			@(negedge clock_in);
			chk("vpe",
				{vpe_valid_ff_out, redistributor_target_ff_out, virtual_pending_base_reg_ff_out,
				vpe_range_ff_out}, {1'b1, r, v[31:12], seed, v[8:4]});
			virtual_pe_index_in = v[15:0] | 16'h0010;
			@(negedge clock_in);
			chk("vpe_beyond", vpe_valid_ff_out, 0);
		end
		chk("left_over", xq.size() + aq.size() + bq.size(), 0);
		report_and_stop();
	end
endmodule
